// File: src/dlp_defines.svh
// Purpose: shared constants of the dual-controller display host port
// Assumes: 20 MHz ref_clk
// Notes: command codes cover the subset the port decodes itself
`ifndef DLP_DEFINES_SVH
`define DLP_DEFINES_SVH

// ==========================================
// geometry
`define DLP_DATA_W 8
`define DLP_NUM_CTL 2
`define DLP_PAGES 4
`define DLP_COLS 80
`define DLP_VIS_COLS 61
`define DLP_COL_MAX 7'h4f

// ==========================================
// instruction codes and masks
`define DLP_CMD_DISP_OFF 8'hae
`define DLP_CMD_DISP_ON 8'haf
`define DLP_CMD_DUTY_16 8'ha8
`define DLP_CMD_DUTY_32 8'ha9
`define DLP_CMD_SOFT_RST 8'he2
`define DLP_CMD_PAGE 8'hb8
`define DLP_CMD_PAGE_MASK 8'hfc
`define DLP_CMD_COL_MASK 8'h80

// ==========================================
// status byte bit positions
`define DLP_STAT_BUSY 7
`define DLP_STAT_OFF 5
`define DLP_STAT_RESET 4

// ==========================================
// timing
`define DLP_REF_CLK_HZ 20000000
`define DLP_SLOW_CLK_HZ 2000
`define DLP_SLOW_TIMEOUT_PERIODS 2

`endif

// File: src/dlp_pkg.sv
// Purpose: types of the dual-controller display host port
// Assumes: nothing
// Notes: none
package dlp_pkg;
    typedef enum logic [1:0] {
        DLP_ACC_IDLE  = 2'b00,
        DLP_ACC_WRITE = 2'b01,
        DLP_ACC_READ  = 2'b10,
        DLP_ACC_FAULT = 2'b11
    } dlp_access_e;

    typedef logic [1:0] dlp_page_t;
    typedef logic [6:0] dlp_col_t;
endpackage

// File: src/dlp_ctrl.sv
// Purpose: one display controller: page/column addressing, display memory, status
// Assumes: strobes are single-cycle pulses from the host port
// Notes: column wraps past the last address back to zero
`timescale 1ns/1ps
`include "dlp_defines.svh"
module dlp_ctrl #(
    parameter int PAGES = `DLP_PAGES,
    parameter int COLS = `DLP_COLS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ctl_rst,
    input wire logic wr_stb,
    input wire logic rd_done,
    input wire logic data_instruction_select,
    input wire logic [7:0] din,
    output logic [7:0] rd_data,
    output dlp_pkg::dlp_page_t page,
    output dlp_pkg::dlp_col_t col,
    output logic disp_on,
    output logic duty32
);
    localparam logic [8:0] COLS_W = 9'(COLS);

    logic [7:0] mem [PAGES*COLS];
    logic [8:0] idx;
    logic data_wr;
    logic cmd_wr;
    logic advance;

    assign idx = 9'(page) * COLS_W + 9'(col);
    assign data_wr = wr_stb && data_instruction_select;
    assign cmd_wr = wr_stb && !data_instruction_select;
    assign advance = (data_wr || (rd_done && data_instruction_select)) && !ctl_rst;

    // ==========================================
    // display memory
    always_ff @(posedge ref_clk) begin
        if (data_wr && !ctl_rst) begin
            mem[idx] <= din; // [R11]
        end
    end

    // ==========================================
    // column address
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ctl_rst) begin
            col <= '0;
        end else if (cmd_wr && din == `DLP_CMD_SOFT_RST) begin
            col <= '0;
        end else if (cmd_wr && (din & `DLP_CMD_COL_MASK) == 8'h00 && din[6:0] <= `DLP_COL_MAX) begin
            col <= din[6:0];
        end else if (advance) begin
            col <= (col == `DLP_COL_MAX) ? 7'h00 : col + 7'h01; // [R12]
        end
    end

    // ==========================================
    // page address
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ctl_rst) begin
            page <= '0;
        end else if (cmd_wr && din == `DLP_CMD_SOFT_RST) begin
            page <= '0;
        end else if (cmd_wr && (din & `DLP_CMD_PAGE_MASK) == `DLP_CMD_PAGE) begin
            page <= din[1:0]; // [R11]
        end
    end

    // ==========================================
    // display on and duty
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ctl_rst) begin
            disp_on <= 1'b0;
            duty32 <= 1'b0;
        end else if (cmd_wr) begin
            if (din == `DLP_CMD_DISP_ON) begin
                disp_on <= 1'b1;
            end else if (din == `DLP_CMD_DISP_OFF) begin
                disp_on <= 1'b0;
            end
            if (din == `DLP_CMD_DUTY_32) begin
                duty32 <= 1'b1;
            end else if (din == `DLP_CMD_DUTY_16) begin
                duty32 <= 1'b0;
            end
        end
    end

    // ==========================================
    // read mux: memory or status
    always_comb begin
        rd_data = 8'h00;
        if (data_instruction_select) begin
            rd_data = mem[idx];
        end else begin
            rd_data[`DLP_STAT_BUSY] = 1'b0;
            rd_data[`DLP_STAT_OFF] = !disp_on;
            rd_data[`DLP_STAT_RESET] = ctl_rst;
        end
    end
endmodule

// File: src/dlp_host_port.sv
// Purpose: host-side 8080 parallel port of a two-controller 122x32 display
// Assumes: all pins sampled synchronously to ref_clk
// Notes: reading with both selects active is refused and flagged
//
// How it works
// R01 - data_instruction_select high means display data, low means instruction.
// R02 - left select addresses left controller, right select addresses right controller.
// R03 - host drives a 2 kHz slow clock; port watches it stays alive.
// R04 - read strobe low with one select active drives that controller's byte out.
// R05 - write strobe falling with select active hands the byte to that controller.
// R06 - reset line falling edge resets both controllers; line stays low afterwards. Port holds both in reset while the line is high.
// R07 - only separate read and write strobes are understood.
// R08 - both selects with read low must never happen; port refuses and flags it.
// R09 - write strobe is shared; only the selects qualify an access.
// R10 - bus is eight bits, two-way; port drives only during reads.
// R11 - each data byte fills one column over eight rows of a page.
// R12 - column auto-increments per byte; host rewinds it after 61 bytes.
// R13 - host sets 1/32 duty so the left controller drives all rows.
`timescale 1ns/1ps
`include "dlp_defines.svh"
module dlp_host_port #(
    parameter int SLOW_TIMEOUT =
        `DLP_SLOW_TIMEOUT_PERIODS * (`DLP_REF_CLK_HZ / `DLP_SLOW_CLK_HZ)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic data_instruction_select,
    input wire logic left_controller_select_n,
    input wire logic right_controller_select_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] db_in,
    output logic [7:0] db_out_q,
    output logic db_oe_q,
    input wire logic external_slow_clock,
    input wire logic interface_reset_line,
    output logic contention_q,
    output logic slow_clock_alive_q,
    output logic ctl_in_reset_q,
    output logic [1:0] display_on_q,
    output logic [1:0] duty_32_q
);
    localparam int NCTL = `DLP_NUM_CTL;

    logic wr_n_q;
    logic rd_n_q;
    logic reset_line_q;
    logic slow_q;
    logic [15:0] slow_cnt_q;
    logic [NCTL-1:0] sel;
    logic [NCTL-1:0] rd_sel_q;
    logic wr_fall;
    logic rd_rise;
    logic ctl_rst;
    dlp_pkg::dlp_access_e acc_d;
    dlp_pkg::dlp_access_e acc_q;
    logic [7:0] rd_data [NCTL];
    dlp_pkg::dlp_page_t page [NCTL];
    dlp_pkg::dlp_col_t col [NCTL];
    logic [NCTL-1:0] disp_on;
    logic [NCTL-1:0] duty32;

    assign sel = {!right_controller_select_n, !left_controller_select_n}; // [R02] [R09]
    assign wr_fall = wr_n_q && !wr_n; // [R05] [R07]
    assign rd_rise = !rd_n_q && rd_n && acc_q == dlp_pkg::DLP_ACC_READ;
    assign ctl_rst = reset_line_q; // [R06]

    // ==========================================
    // pin history
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            reset_line_q <= 1'b0;
            slow_q <= 1'b0;
        end else begin
            wr_n_q <= wr_n;
            rd_n_q <= rd_n;
            reset_line_q <= interface_reset_line;
            slow_q <= external_slow_clock;
        end
    end

    // ==========================================
    // access classification
    always_comb begin
        acc_d = dlp_pkg::DLP_ACC_IDLE;
        if (!rd_n && (&sel)) begin
            acc_d = dlp_pkg::DLP_ACC_FAULT; // [R08]
        end else if (!rd_n && (|sel)) begin
            acc_d = dlp_pkg::DLP_ACC_READ; // [R04]
        end else if (!wr_n && (|sel)) begin
            acc_d = dlp_pkg::DLP_ACC_WRITE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_q <= dlp_pkg::DLP_ACC_IDLE;
            rd_sel_q <= '0;
        end else begin
            acc_q <= acc_d;
            if (acc_d == dlp_pkg::DLP_ACC_READ) begin
                rd_sel_q <= sel;
            end
        end
    end

    // ==========================================
    // controllers
    for (genvar i = 0; i < NCTL; i++) begin : g_ctl
        dlp_ctrl u_ctl (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .ctl_rst(ctl_rst),
            .wr_stb(wr_fall && sel[i] && rd_n), // [R05]
            .rd_done(rd_rise && rd_sel_q[i]),
            .data_instruction_select(data_instruction_select), // [R01]
            .din(db_in),
            .rd_data(rd_data[i]),
            .page(page[i]),
            .col(col[i]),
            .disp_on(disp_on[i]),
            .duty32(duty32[i])
        );
    end

    // ==========================================
    // bus drive
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            db_out_q <= 8'h00;
            db_oe_q <= 1'b0;
            contention_q <= 1'b0;
        end else begin
            db_oe_q <= (acc_d == dlp_pkg::DLP_ACC_READ); // [R04] [R10]
            db_out_q <= sel[1] ? rd_data[1] : rd_data[0];
            contention_q <= (acc_d == dlp_pkg::DLP_ACC_FAULT); // [R08]
        end
    end

    // ==========================================
    // slow clock watchdog
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slow_cnt_q <= '0;
            slow_clock_alive_q <= 1'b0;
        end else if (slow_q != external_slow_clock) begin
            slow_cnt_q <= '0; // [R03]
            slow_clock_alive_q <= 1'b1;
        end else if (slow_cnt_q >= 16'(SLOW_TIMEOUT)) begin
            slow_clock_alive_q <= 1'b0;
        end else begin
            slow_cnt_q <= slow_cnt_q + 16'h0001;
        end
    end

    // ==========================================
    // status outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_in_reset_q <= 1'b0;
            display_on_q <= '0;
            duty_32_q <= '0;
        end else begin
            ctl_in_reset_q <= ctl_rst; // [R06]
            display_on_q <= disp_on;
            duty_32_q <= duty32; // [R13]
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_left_data_write;
        wr_n_q && !wr_n && rd_n && !left_controller_select_n
            && right_controller_select_n && data_instruction_select && !reset_line_q;
    endsequence

    property p_read_drive;
        !rd_n && ($countones(sel) == 1) |=> db_oe_q;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven"); // [R04]

    property p_both_refused;
        !rd_n && (&sel) |=> !db_oe_q && contention_q;
    endproperty
    a_both_refused: assert property (p_both_refused) else $error("contention not refused"); // [R08]

    property p_release;
        rd_n |=> !db_oe_q;
    endproperty
    a_release: assert property (p_release) else $error("bus driven outside read"); // [R10]

    property p_reset_edge;
        (reset_line_q && !interface_reset_line) ##1 !interface_reset_line
            |-> ctl_in_reset_q ##1 !ctl_in_reset_q;
    endproperty
    a_reset_edge: assert property (p_reset_edge) else $error("reset edge mishandled"); // [R06]

    property p_col_step;
        s_left_data_write and (col[0] != `DLP_COL_MAX)
            |=> col[0] == $past(col[0]) + 7'h01;
    endproperty
    a_col_step: assert property (p_col_step) else $error("column did not step"); // [R12]

    property p_col_wrap;
        s_left_data_write and (col[0] == `DLP_COL_MAX) |=> col[0] == 7'h00;
    endproperty
    a_col_wrap: assert property (p_col_wrap) else $error("column did not wrap"); // [R12]

    property p_page_set;
        wr_n_q && !wr_n && rd_n && !left_controller_select_n && !data_instruction_select
            && !reset_line_q && (db_in & `DLP_CMD_PAGE_MASK) == `DLP_CMD_PAGE
            |=> page[0] == $past(db_in[1:0]);
    endproperty
    a_page_set: assert property (p_page_set) else $error("page not set"); // [R11]

    property p_duty;
        wr_n_q && !wr_n && rd_n && !left_controller_select_n && !data_instruction_select
            && !reset_line_q && db_in == `DLP_CMD_DUTY_32 ##1 !reset_line_q
            |=> duty_32_q[0];
    endproperty
    a_duty: assert property (p_duty) else $error("duty not set"); // [R13]

    property p_status_read;
        !rd_n && !data_instruction_select && !left_controller_select_n
            && right_controller_select_n |=> db_out_q[`DLP_STAT_OFF] == !$past(disp_on[0]);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status byte wrong"); // [R01]

    property p_slow_alive;
        slow_q != external_slow_clock |=> slow_clock_alive_q && slow_cnt_q == 16'h0000;
    endproperty
    a_slow_alive: assert property (p_slow_alive) else $error("slow clock not seen"); // [R03]
endmodule

// File: verif/dlp_host_model.sv
// Purpose: host processor model on the 8080-style bus of the display port
// Assumes: ref_clk rising edge, bus tasks called one at a time
// Notes: slow clock toggles every SLOW_HALF cycles while slow_run is high
`timescale 1ns/1ps
module dlp_host_model #(
    parameter int SLOW_HALF = 20
) (
    input wire logic ref_clk,
    input wire logic slow_run,
    input wire logic [7:0] db_seen,
    input wire logic db_oe_q,
    input wire logic contention_q,
    output logic data_instruction_select,
    output logic left_controller_select_n,
    output logic right_controller_select_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] host_d,
    output logic host_oe,
    output logic external_slow_clock
);
    int cnt;

    initial begin
        data_instruction_select = 1'b0;
        left_controller_select_n = 1'b1;
        right_controller_select_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        host_d = 8'h00;
        host_oe = 1'b0;
        external_slow_clock = 1'b0;
        cnt = 0;
    end

    // =====================================
    // slow clock, free running while enabled
    always @(posedge ref_clk) begin
        if (slow_run) begin
            cnt <= (cnt == SLOW_HALF - 1) ? 0 : cnt + 1;
            if (cnt == SLOW_HALF - 1) begin
                external_slow_clock <= ~external_slow_clock;
            end
        end
    end

    // =====================================
    // bus cycles; sel[0] left, sel[1] right
    task automatic wr(input logic dsel, input logic [1:0] sel, input logic [7:0] d);
        @(posedge ref_clk);
        data_instruction_select <= dsel;
        left_controller_select_n <= ~sel[0];
        right_controller_select_n <= ~sel[1];
        host_d <= d;
        host_oe <= 1'b1;
        @(posedge ref_clk);
        wr_n <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        wr_n <= 1'b1;
        @(posedge ref_clk);
        left_controller_select_n <= 1'b1;
        right_controller_select_n <= 1'b1;
        host_oe <= 1'b0;
    endtask

    task automatic rd(input logic dsel, input logic [1:0] sel, output logic [7:0] d,
                      output logic oe, output logic cont);
        @(posedge ref_clk);
        data_instruction_select <= dsel;
        left_controller_select_n <= ~sel[0]; // both only when commanded
        right_controller_select_n <= ~sel[1];
        rd_n <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        d = db_seen;
        oe = db_oe_q;
        cont = contention_q;
        rd_n <= 1'b1;
        @(posedge ref_clk);
        left_controller_select_n <= 1'b1;
        right_controller_select_n <= 1'b1;
        @(posedge ref_clk);
    endtask
endmodule

// File: verif/test_dual_controller_lcd_host_port.sv
// Purpose: self-checking bench of the display host port
// Assumes: 20 MHz ref_clk, shortened slow-clock watchdog
// Notes: table of instruction writes first, hand tests after
`timescale 1ns/1ps
module test_dual_controller_lcd_host_port;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] code;
        logic [1:0] disp;
        logic [1:0] duty;
    } dlp_row_s;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic line = 1'b0;
    logic slow_run = 1'b1;
    logic dsel, cs_l_n, cs_r_n, rd_n, wr_n, host_oe, slow_clk, oe, cont;
    logic [7:0] host_d, db_in, db_out_q, d;
    logic db_oe_q, contention_q, alive, in_rst;
    logic [1:0] disp, duty;
    int num_errors = 0;
    int n_tests = 0;
    int n;
    dlp_row_s rows [8] = '{
        '{2'b01, 8'haf, 2'b01, 2'b00}, '{2'b10, 8'ha9, 2'b01, 2'b10},
        '{2'b11, 8'haf, 2'b11, 2'b10}, '{2'b01, 8'ha9, 2'b11, 2'b11},
        '{2'b10, 8'hae, 2'b01, 2'b11}, '{2'b11, 8'ha8, 2'b01, 2'b00},
        '{2'b11, 8'haf, 2'b11, 2'b00}, '{2'b11, 8'ha9, 2'b11, 2'b11}};

    always #25 ref_clk = ~ref_clk;

    // released bus shows the inverse of the last host byte
    assign db_in = db_oe_q ? db_out_q : (host_oe ? host_d : ~host_d);

    dlp_host_port #(.SLOW_TIMEOUT(50)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .data_instruction_select(dsel), .left_controller_select_n(cs_l_n),
        .right_controller_select_n(cs_r_n), .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in),
        .db_out_q(db_out_q), .db_oe_q(db_oe_q), .external_slow_clock(slow_clk),
        .interface_reset_line(line), .contention_q(contention_q),
        .slow_clock_alive_q(alive), .ctl_in_reset_q(in_rst), .display_on_q(disp),
        .duty_32_q(duty));

    dlp_host_model host (.ref_clk(ref_clk), .slow_run(slow_run), .db_seen(db_in),
        .db_oe_q(db_oe_q), .contention_q(contention_q), .data_instruction_select(dsel),
        .left_controller_select_n(cs_l_n), .right_controller_select_n(cs_r_n),
        .rd_n(rd_n), .wr_n(wr_n), .host_d(host_d), .host_oe(host_oe),
        .external_slow_clock(slow_clk));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("tests=%0d errors=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // =====================================
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        chk({db_oe_q, contention_q, in_rst, disp, duty}, 8'h00);
        rst_n <= 1'b1;
        for (n = 0; n < 100 && alive !== 1'b1; n++) @(posedge ref_clk);
        chk({7'h0, alive}, 8'h01);
        if (alive !== 1'b1) finish_test();
        foreach (rows[i]) begin
            host.wr(1'b0, rows[i].sel, rows[i].code);
            repeat (2) @(posedge ref_clk);
            chk({4'h0, disp, duty}, {4'h0, rows[i].disp, rows[i].duty});
        end
        host.wr(0, 2'b01, 8'hb9);
        host.wr(0, 2'b01, 8'h00);
        host.wr(1, 2'b01, 8'h5a);
        host.wr(1, 2'b01, 8'hc3);
        host.wr(1, 2'b01, 8'h81);
        host.wr(0, 2'b10, 8'hb9);
        host.wr(0, 2'b10, 8'h00);
        host.wr(1, 2'b10, 8'h11);
        host.wr(0, 2'b01, 8'h01);
        host.rd(1, 2'b01, d, oe, cont);
        chk(d, 8'hc3);
        chk({7'h0, oe}, 8'h01);
        host.rd(1, 2'b01, d, oe, cont);
        chk(d, 8'h81);
        host.wr(0, 2'b01, 8'he2);
        host.wr(1, 2'b01, 8'h77);
        host.wr(0, 2'b01, 8'hb9);
        host.wr(0, 2'b01, 8'h00);
        host.rd(1, 2'b01, d, oe, cont);
        chk(d, 8'h5a);
        host.wr(0, 2'b10, 8'h00);
        host.rd(1, 2'b10, d, oe, cont);
        chk(d, 8'h11);
        host.rd(0, 2'b01, d, oe, cont);
        chk(d, 8'h00);
        host.rd(1, 2'b11, d, oe, cont);
        chk({6'h0, oe, cont}, 8'h01);
        line <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({7'h0, in_rst}, 8'h01);
        host.rd(0, 2'b01, d, oe, cont);
        chk(d, 8'h30);
        host.wr(0, 2'b01, 8'haf);
        line <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({3'h0, in_rst, disp, duty}, 8'h00);
        host.wr(0, 2'b01, 8'haf);
        repeat (2) @(posedge ref_clk);
        chk({6'h0, disp}, 8'h01);
        host.rd(1, 2'b01, d, oe, cont);
        chk(d, 8'h77);
        host.wr(0, 2'b01, 8'h4f);
        host.wr(1, 2'b01, 8'h3c);
        host.rd(1, 2'b01, d, oe, cont);
        chk(d, 8'h77);
        host.wr(0, 2'b01, 8'h4f);
        host.rd(1, 2'b01, d, oe, cont);
        chk(d, 8'h3c);
        slow_run <= 1'b0;
        for (n = 0; n < 120 && alive !== 1'b0; n++) @(posedge ref_clk);
        chk({6'h0, alive, n >= 25}, 8'h01);
        if (alive !== 1'b0) finish_test();
        slow_run <= 1'b1;
        for (n = 0; n < 60 && alive !== 1'b1; n++) @(posedge ref_clk);
        chk({7'h0, alive}, 8'h01);
        if (alive !== 1'b1) finish_test();
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({db_oe_q, contention_q, alive, disp, duty}, 8'h00);
        rst_n <= 1'b1;
        finish_test();
    end
endmodule
